// >>> hpds_defines.svh
// constants for the core-side half of the byte-wide host port
// assumes an includer that also imports hpds_pkg for the types
// Summary of operation
// - command pending status bit 2 follows the host command request bit.
// - taking the command exception clears the request and pending bit.
// - host clearing its command request also clears the pending bit.
// - status bits 3 and 4 show host flags 0 and 1; host-only.
// - status bits 5 and 6 read as zero.
// - status bit 7 is set when either transfer size select bit is set.
// - the direction not used by DMA stays usable by the core.
// - host word moves to receive word when both flags clear; sets both.
// - receive word is read-only, valid while full; reading clears full.
// - transmit word is write-only; each write clears transmit empty unless a move or host initialise sets it that cycle.
// - transmit word copies to host bytes when both flags clear; sets both.
// - software should wait for transmit empty before writing again.
// - no reset alters the receive or transmit words.
// - four reset sources: pin, software, port control bits zero, stop.
// - all resets clear status flags, set tx empty; control on pin/software only.
// - internal interrupt request when status bit and its enable are set.
// - host command interrupt may target any vector table entry.
// - data requests clear by data access; command by acknowledge.
// - flags changed from the host side are synchronised one by one.
// - software should read encoded host flags twice for a consistent value.
// - host sees eight byte-wide locations only it can access.
// - an internal DMA address counter spares the host address lines.
// - control bits 0, 1, 2 enable rx full, tx empty, command requests.
// - host initialise clears rx full and sets tx empty independently.
// - status reads land on the low byte, upper bits zero.
`ifndef HPDS_DEFINES_SVH
`define HPDS_DEFINES_SVH
`define HPDS_ADDR_CONTROL 2'h0
`define HPDS_ADDR_STATUS 2'h1
`define HPDS_ADDR_DATA 2'h2
`define HPDS_CTL_RX_IE 0
`define HPDS_CTL_TX_IE 1
`define HPDS_CTL_CMD_IE 2
`define HPDS_CTL_WIDTH 5
`define HPDS_CTL_RESET 5'h00
`define HPDS_DMA_LAST 2'h3
// host tx empty rests high so a reset cannot fake a waiting host word
`define HPDS_SYNC_RESET 7'h02
`endif

// >>> hpds_pkg.sv
// types shared by the core-side host port half
// assumes nothing beyond a SystemVerilog compiler
package hpds_pkg;
  // host-side levels that need synchronising
  typedef struct packed {
    logic cmd_req;
    logic flag1;
    logic flag0;
    logic size_hi;
    logic size_lo;
    logic tx_empty;
    logic rx_full;
  } hpds_host_t;
  // command pending tracking, gray on every step except drain back to idle
  typedef enum logic [1:0] {
    HPDS_CMD_IDLE = 2'b00,
    HPDS_CMD_PEND = 2'b01,
    HPDS_CMD_DRAIN = 2'b11
  } hpds_cmd_t;
endpackage : hpds_pkg

// >>> hpds_port.sv
// core-side half of the byte-wide host port: status, control, data words
// assumes host-side registers live outside and talk through level/pulse ports
`timescale 1ns/1ps
`include "hpds_defines.svh"
module hpds_port
  import hpds_pkg::*;
#(
  parameter int DATA_W = 24 // word width
) (
  input wire logic sys_clk, // core clock, 50 MHz
  input wire logic rst, // hardware reset, sync high
  input wire logic sw_reset, // software reset instruction
  input wire logic stop_reset, // stop instruction reset
  input wire logic [1:0] port_b_control, // both zero gives individual reset
  input wire logic core_rd, // core read strobe
  input wire logic core_wr, // core write strobe
  input wire logic [1:0] core_addr, // register select
  input wire logic [DATA_W-1:0] core_wdata, // core write data
  output logic [DATA_W-1:0] core_rdata, // core read data
  input wire logic core_cmd_ack, // command exception taken
  input wire hpds_host_t host_in, // raw host-side levels
  input wire logic [DATA_W-1:0] host_tx_bytes, // host transmit bytes
  input wire logic [5:0] cmd_vector, // host-chosen vector
  input wire logic init_clear_rx, // host init clears rx full
  input wire logic init_set_tx, // host init sets tx empty
  input wire logic dma_ack, // one pulse per dma byte
  input wire logic dma_init, // preload dma counter
  output logic [DATA_W-1:0] host_rx_bytes, // word to host receive bytes
  output logic host_rx_load, // pulse: sets host rx full
  output logic host_tx_take, // pulse: sets host tx empty
  output logic host_cmd_clear, // pulse: clears host command request
  output logic [1:0] dma_addr, // dma register select
  output logic irq_rx, // receive full request
  output logic irq_tx, // transmit empty request
  output logic irq_cmd, // host command request
  output logic [5:0] irq_cmd_vector // vector for command request
);

  // reset groups
  logic full_rst;
  logic port_rst;
  assign full_rst = rst | sw_reset;
  assign port_rst = full_rst | stop_reset | (port_b_control == 2'b00);

  // two-stage synchroniser; first stage read only by second
  hpds_host_t sync_a;
  hpds_host_t sync_b;
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      sync_a <= `HPDS_SYNC_RESET;
      sync_b <= `HPDS_SYNC_RESET;
    end else begin
      sync_a <= host_in;
      sync_b <= sync_a;
    end
  end

  // decoding used by read and write paths
  function automatic logic hit(input logic [1:0] a, input logic [1:0] r, input logic s);
    hit = s & (a == r);
  endfunction : hit

  logic rd_data;
  logic wr_data;
  logic wr_ctl;
  logic rd_stat;
  assign rd_data = hit(core_addr, `HPDS_ADDR_DATA, core_rd);
  assign wr_data = hit(core_addr, `HPDS_ADDR_DATA, core_wr);
  assign wr_ctl = hit(core_addr, `HPDS_ADDR_CONTROL, core_wr);
  assign rd_stat = hit(core_addr, `HPDS_ADDR_STATUS, core_rd);

  // control register, cleared by pin and software reset only
  logic [`HPDS_CTL_WIDTH-1:0] ctl;
  always_ff @(posedge sys_clk) begin
    if (full_rst) begin
      ctl <= `HPDS_CTL_RESET;
    end else if (wr_ctl) begin
      ctl <= core_wdata[`HPDS_CTL_WIDTH-1:0];
    end
  end

  // words themselves carry no reset
  logic [DATA_W-1:0] rx_word;
  logic [DATA_W-1:0] tx_word;
  logic rx_full;
  logic tx_empty;
  logic rx_wait;
  logic tx_wait;
  logic move_in;
  logic move_out;

  // host-to-core move; wait until host empty has been seen to avoid
  // re-taking the same word through the stale synchroniser
  assign move_in = !sync_b.tx_empty && !rx_full && !rx_wait;
  assign move_out = !tx_empty && !sync_b.rx_full && !tx_wait;

  always_ff @(posedge sys_clk) begin
    if (move_in) begin
      rx_word <= host_tx_bytes;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_data) begin
      tx_word <= core_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (move_out) begin
      host_rx_bytes <= tx_word;
    end
  end

  // receive full flag; a move wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      rx_full <= 1'b0;
    end else if (move_in) begin
      rx_full <= 1'b1;
    end else if (rd_data || init_clear_rx) begin
      rx_full <= 1'b0;
    end
  end

  // transmit empty flag; a move wins over a same-cycle write
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      tx_empty <= 1'b1;
    end else if (move_out || init_set_tx) begin
      tx_empty <= 1'b1;
    end else if (wr_data) begin
      tx_empty <= 1'b0;
    end
  end

  // hold-offs until host-side flags come back through the synchroniser
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      rx_wait <= 1'b0;
      tx_wait <= 1'b0;
    end else begin
      if (move_in) begin
        rx_wait <= 1'b1;
      end else if (sync_b.tx_empty) begin
        rx_wait <= 1'b0;
      end
      if (move_out) begin
        tx_wait <= 1'b1;
      end else if (sync_b.rx_full) begin
        tx_wait <= 1'b0;
      end
    end
  end

  // host handshake pulses
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      host_rx_load <= 1'b0;
      host_tx_take <= 1'b0;
    end else begin
      host_rx_load <= move_out;
      host_tx_take <= move_in;
    end
  end

  // command pending: follows the request, dropped on acknowledge and
  // held low until the host request is seen low, so a stale level
  // cannot raise it again
  hpds_cmd_t cmd_state;
  hpds_cmd_t next_cmd_state;
  always_comb begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      HPDS_CMD_IDLE: begin
        if (sync_b.cmd_req) begin
          next_cmd_state = HPDS_CMD_PEND;
        end
      end
      HPDS_CMD_PEND: begin
        if (core_cmd_ack) begin
          next_cmd_state = HPDS_CMD_DRAIN;
        end else if (!sync_b.cmd_req) begin
          next_cmd_state = HPDS_CMD_IDLE;
        end
      end
      HPDS_CMD_DRAIN: begin
        if (!sync_b.cmd_req) begin
          next_cmd_state = HPDS_CMD_IDLE;
        end
      end
      default: begin
        next_cmd_state = HPDS_CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      cmd_state <= HPDS_CMD_IDLE;
    end else begin
      cmd_state <= next_cmd_state;
    end
  end

  logic cmd_pending;
  assign cmd_pending = (cmd_state == HPDS_CMD_PEND);

  // clear pulse back to the host request bit
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      host_cmd_clear <= 1'b0;
    end else begin
      host_cmd_clear <= cmd_pending && core_cmd_ack;
    end
  end

  // status byte; dma bit from either size select bit
  logic [7:0] status;
  logic dma_on;
  assign dma_on = sync_b.size_hi | sync_b.size_lo;
  assign status = {dma_on, 2'b00, sync_b.flag1, sync_b.flag0,
                   cmd_pending, tx_empty, rx_full};

  // registered read data; status on the low byte
  always_ff @(posedge sys_clk) begin
    if (full_rst) begin
      core_rdata <= '0;
    end else if (rd_stat) begin
      core_rdata <= {{(DATA_W-8){1'b0}}, status};
    end else if (rd_data) begin
      core_rdata <= rx_word;
    end else if (hit(core_addr, `HPDS_ADDR_CONTROL, core_rd)) begin
      core_rdata <= {{(DATA_W-`HPDS_CTL_WIDTH){1'b0}}, ctl};
    end else begin
      core_rdata <= '0;
    end
  end

  // internal interrupt requests, cleared by data access or acknowledge
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      irq_rx <= 1'b0;
      irq_tx <= 1'b0;
      irq_cmd <= 1'b0;
    end else begin
      irq_rx <= rx_full && !rd_data && ctl[`HPDS_CTL_RX_IE];
      irq_tx <= tx_empty && !wr_data && ctl[`HPDS_CTL_TX_IE];
      irq_cmd <= cmd_pending && !core_cmd_ack && ctl[`HPDS_CTL_CMD_IE];
    end
  end

  // any vector may be chosen; sampled while idle, held while pending and draining
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      irq_cmd_vector <= '0;
    end else if (cmd_state == HPDS_CMD_IDLE) begin
      irq_cmd_vector <= cmd_vector;
    end
  end

  // dma address counter: preload with size bits, step, reload at last
  always_ff @(posedge sys_clk) begin
    if (port_rst) begin
      dma_addr <= 2'h0;
    end else if (dma_init) begin
      dma_addr <= {sync_b.size_hi, sync_b.size_lo};
    end else if (dma_ack && dma_on) begin
      if (dma_addr == `HPDS_DMA_LAST) begin
        dma_addr <= {sync_b.size_hi, sync_b.size_lo};
      end else begin
        dma_addr <= dma_addr + 2'h1;
      end
    end
  end

endmodule : hpds_port

// >>> hpds_port_assertions.sv
// checker for the core-side host port half
// assumes it is bound onto hpds_port, one clock domain
`timescale 1ns/1ps
`include "hpds_defines.svh"
module hpds_port_assertions
  import hpds_pkg::*;
#(
  parameter int DATA_W = 24 // word width
) (
  input wire logic sys_clk, // core clock
  input wire logic rst, // sync reset
  input wire logic core_rd, // read strobe
  input wire logic core_wr, // write strobe
  input wire logic [1:0] core_addr, // register select
  input wire logic [DATA_W-1:0] core_wdata, // write data
  input wire logic [DATA_W-1:0] core_rdata, // read data
  input wire logic core_cmd_ack, // command taken
  input wire hpds_host_t host_in, // host levels
  input wire logic [DATA_W-1:0] host_rx_bytes, // word to host
  input wire logic host_rx_load, // host rx load
  input wire logic host_tx_take, // host tx take
  input wire logic host_cmd_clear, // command clear
  input wire logic irq_rx, // rx request
  input wire logic irq_tx, // tx request
  input wire logic irq_cmd, // command request
  input wire logic [5:0] irq_cmd_vector // command vector
);
  default clocking cb @(posedge sys_clk); endclocking
  logic [DATA_W-1:0] last_wr;
  // last core word, what the host must receive
  always_ff @(posedge sys_clk) begin
    if (core_wr && core_addr == `HPDS_ADDR_DATA) last_wr <= core_wdata;
  end
  sequence ack_s; core_cmd_ack && irq_cmd; endsequence
  sequence clr_s; host_cmd_clear ##1 !host_cmd_clear; endsequence
  status_zero_a: assert property (disable iff (rst) core_rd && core_addr == `HPDS_ADDR_STATUS |=>
    core_rdata[DATA_W-1:8] == '0 && core_rdata[6:5] == 2'h0) else $error("status spare bits set");
  tx_load_a: assert property (disable iff (rst) host_rx_load |-> host_rx_bytes == last_wr ##1
    !host_rx_load) else $error("host word wrong");
  rx_take_a: assert property (disable iff (rst) host_tx_take |=> !host_tx_take) else $error("take repeats");
  rx_irq_drop_a: assert property (disable iff (rst) irq_rx && core_rd && core_addr == `HPDS_ADDR_DATA
    |=> !irq_rx) else $error("rx request stays");
  tx_irq_drop_a: assert property (disable iff (rst) irq_tx && core_wr && core_addr == `HPDS_ADDR_DATA
    |=> !irq_tx) else $error("tx request stays");
  cmd_ack_a: assert property (disable iff (rst) ack_s |=> clr_s) else $error("no command clear");
  cmd_drop_a: assert property (disable iff (rst) ack_s |=> !irq_cmd [*2]) else $error("command stays");
  cmd_sync_a: assert property (disable iff (rst) $rose(host_in.cmd_req) && !irq_cmd |-> !irq_cmd [*3])
    else $error("command too early");
  vec_hold_a: assert property (disable iff (rst) irq_cmd && $past(irq_cmd) |-> $stable(irq_cmd_vector))
    else $error("vector moved");
  reset_clear_a: assert property (rst |=> !irq_rx && !irq_tx && !irq_cmd && !host_rx_load)
    else $error("reset left requests");
endmodule : hpds_port_assertions
bind hpds_port hpds_port_assertions #(.DATA_W(DATA_W)) chk_u (.sys_clk(sys_clk), .rst(rst),
  .core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
  .core_rdata(core_rdata), .core_cmd_ack(core_cmd_ack), .host_in(host_in), .host_rx_bytes(host_rx_bytes),
  .host_rx_load(host_rx_load), .host_tx_take(host_tx_take), .host_cmd_clear(host_cmd_clear),
  .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_cmd(irq_cmd), .irq_cmd_vector(irq_cmd_vector));

// >>> hpds_host_model.sv
// host-side model: levels and byte registers of the host half
// assumes the bench calls its tasks at falling edges
`timescale 1ns/1ps
module hpds_host_model
  import hpds_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic host_rx_load, // word reaches host
  input wire logic host_tx_take, // host word taken
  input wire logic host_cmd_clear, // command taken
  output hpds_host_t host_in, // host levels
  output logic [23:0] host_tx_bytes // host transmit word
);
  logic slow = 1'b0; // host leaves rx full standing
  initial host_in = 7'h02;
  initial host_tx_bytes = 24'h000000;
  // reactions to the port's pulses
  always @(posedge sys_clk) begin
    if (host_tx_take) begin
      host_in.tx_empty <= 1'b1;
      host_tx_bytes <= ~host_tx_bytes; // released, stale value must not pass
    end
    if (host_rx_load) host_in.rx_full <= 1'b1;
    else if (!slow) host_in.rx_full <= 1'b0;
    if (host_cmd_clear) host_in.cmd_req <= 1'b0;
  end
  task send(input logic [23:0] w);
    host_tx_bytes = w;
    host_in.tx_empty = 1'b0;
  endtask : send
  task drain;
    host_in.rx_full = 1'b0;
  endtask : drain
  // command request, flags and size are host-only levels
  task levels(input logic [4:0] v);
    {host_in.cmd_req, host_in.flag1, host_in.flag0, host_in.size_hi, host_in.size_lo} = v;
  endtask : levels
endmodule : hpds_host_model

// >>> tb_host_port_dsp_side_status_and_data.sv
// bench for the core-side host port half with a host-side model
// assumes hpds_port, hpds_host_model and the checker are compiled first
`timescale 1ns/1ps
`include "hpds_defines.svh"
module tb_host_port_dsp_side_status_and_data
  import hpds_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, sw_reset = 1'b0, stop_reset = 1'b0, rd_seen = 1'b0;
  logic core_rd = 1'b0, core_wr = 1'b0, core_cmd_ack = 1'b0, init_clear_rx = 1'b0, init_set_tx = 1'b0;
  logic dma_ack = 1'b0, dma_init = 1'b0, host_rx_load, host_tx_take, host_cmd_clear, irq_rx, irq_tx, irq_cmd;
  logic [1:0] port_b_control = 2'h3, core_addr = 2'h0, dma_addr;
  logic [23:0] core_wdata = 24'h000000, core_rdata, host_rx_bytes, host_tx_bytes, w;
  logic [5:0] cmd_vector = 6'h00, irq_cmd_vector, v;
  hpds_host_t host_in;
  logic [23:0] rq[$], hq[$];
  int miscompares = 0, tests_run = 0;
  hpds_port #(.DATA_W(24)) dut_u (.sys_clk(sys_clk), .rst(rst), .sw_reset(sw_reset), .stop_reset(stop_reset),
    .port_b_control(port_b_control), .core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .core_cmd_ack(core_cmd_ack), .host_in(host_in),
    .host_tx_bytes(host_tx_bytes), .cmd_vector(cmd_vector), .init_clear_rx(init_clear_rx),
    .init_set_tx(init_set_tx), .dma_ack(dma_ack), .dma_init(dma_init), .host_rx_bytes(host_rx_bytes),
    .host_rx_load(host_rx_load), .host_tx_take(host_tx_take), .host_cmd_clear(host_cmd_clear),
    .dma_addr(dma_addr), .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_cmd(irq_cmd), .irq_cmd_vector(irq_cmd_vector));
  hpds_host_model host_u (.sys_clk(sys_clk), .host_rx_load(host_rx_load), .host_tx_take(host_tx_take),
    .host_cmd_clear(host_cmd_clear), .host_in(host_in), .host_tx_bytes(host_tx_bytes));
  initial forever #10 sys_clk = ~sys_clk;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one bus cycle; for a read the data argument is the expected answer
  task op(input int r, input int wr, input logic [1:0] a, input logic [23:0] d);
    {core_rd, core_wr, core_addr, core_wdata} = {r != 0, wr != 0, a, d};
    if (r != 0) rq.push_back(d);
    @(negedge sys_clk);
  endtask : op
  task idle(input int n);
    {core_rd, core_wr} = 2'b00;
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic pulse(ref logic s);
    // drop any strobe left by a previous op, or it repeats unnoted
    {core_rd, core_wr} = 2'b00;
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask : pulse
  task fin(input int n);
    idle(2);
    $display("test %0d done", n);
  endtask : fin
  task print_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // results are paired with the oldest note of their kind
  always @(posedge sys_clk) rd_seen <= core_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) check(core_rdata, rq.pop_front());
    if (host_rx_load) check(host_rx_bytes, hq.pop_front());
  end
  // watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(83));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000002);
    op(0, 1, 2'h3, 24'hFFFFFF);
    op(1, 0, 2'h3, 24'h000000);
    op(1, 0, `HPDS_ADDR_CONTROL, 24'h000000);
    fin(1);
    // host to core: second word must wait for the first read
    op(0, 1, `HPDS_ADDR_CONTROL, 24'h000001);
    w = 24'($urandom);
    host_u.send(w);
    idle(6);
    check(24'(irq_rx), 24'h000001);
    check(24'(irq_tx), 24'h000000);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000003);
    host_u.send(~w);
    idle(6);
    op(1, 0, `HPDS_ADDR_DATA, w);
    idle(6);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000003);
    pulse(init_clear_rx);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000002);
    fin(2);
    // core to host with a stalling host
    op(0, 1, `HPDS_ADDR_CONTROL, 24'h000003);
    host_u.slow = 1'b1;
    idle(2);
    check(24'(irq_tx), 24'h000001);
    hq.push_back(w);
    op(0, 1, `HPDS_ADDR_DATA, w);
    idle(4);
    op(0, 1, `HPDS_ADDR_DATA, ~w);
    idle(6);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000000);
    hq.push_back(~w);
    host_u.drain();
    idle(6);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000002);
    op(0, 1, `HPDS_ADDR_DATA, w);
    pulse(init_set_tx);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000002);
    host_u.slow = 1'b0;
    host_u.drain();
    fin(3);
    // every flag pair and size code, then the dma counter
    for (int i = 0; i < 4; i++) begin
      host_u.levels({1'b0, 2'(i), 2'(i)});
      idle(5);
      op(1, 0, `HPDS_ADDR_STATUS, {16'h0000, i != 0, 2'h0, 2'(i), 3'h2});
    end
    op(0, 1, `HPDS_ADDR_STATUS, 24'h000000);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h00009A);
    host_u.levels(5'h02);
    idle(4);
    pulse(dma_init);
    check(24'(dma_addr), 24'h000002);
    pulse(dma_ack);
    check(24'(dma_addr), 24'h000003);
    idle(1);
    pulse(dma_ack);
    check(24'(dma_addr), 24'h000002);
    fin(4);
    // host command: taken by acknowledge, then cancelled by the host
    op(0, 1, `HPDS_ADDR_CONTROL, 24'h000004);
    v = 6'($urandom);
    cmd_vector = v;
    host_u.levels(5'h10);
    idle(6);
    check(24'(irq_cmd), 24'h000001);
    check(24'(irq_cmd_vector), 24'(v));
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000006);
    pulse(core_cmd_ack);
    idle(6);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000002);
    host_u.levels(5'h10);
    idle(6);
    host_u.levels(5'h00);
    idle(6);
    op(1, 0, `HPDS_ADDR_STATUS, 24'h000002);
    fin(5);
    // stop, individual and software resets with a word pending
    for (int k = 0; k < 3; k++) begin
      w = 24'($urandom);
      host_u.send(w);
      idle(6);
      {stop_reset, port_b_control, sw_reset} = {k == 0, k == 1 ? 2'h0 : 2'h3, k == 2};
      idle(1);
      {stop_reset, port_b_control, sw_reset} = 4'h6;
      idle(4);
      op(1, 0, `HPDS_ADDR_STATUS, 24'h000002);
      op(1, 0, `HPDS_ADDR_CONTROL, k == 2 ? 24'h000000 : 24'h000004);
      op(1, 0, `HPDS_ADDR_DATA, w);
    end
    fin(6);
    print_verdict();
  end
endmodule : tb_host_port_dsp_side_status_and_data
